// ===== logic/uart_pkg.sv
package uart_pkg;

    // Character layout
    localparam int DATA_BITS = 8;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam logic [2:0] FIRST_DATA_BIT = 3'h0;
    localparam logic STOP_ONE = 1'h0;
    localparam logic STOP_TWO = 1'h1;

    // Line levels
    localparam logic LINE_IDLE = 1'h1;
    localparam logic LINE_START = 1'h0;

    // Divisor handling
    localparam logic [15:0] DIVISOR_MIN = 16'h0001;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    // Reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Address matching schemes
    localparam logic [1:0] SCHEME_ALL_BYTES = 2'h0;
    localparam logic [1:0] SCHEME_ADDR_ONLY = 2'h1;
    localparam logic [1:0] SCHEME_MATCH_ADDR_DATA = 2'h2;
    localparam logic [1:0] SCHEME_MATCH_DATA = 2'h3;

    // Transmitter states
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP
    } tx_state_type;

    // Receiver states
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP
    } rx_state_type;

    // Parity over one byte; odd_sel picks odd parity
    function automatic logic parity_bit(input logic [7:0] data, input logic odd_sel);
        parity_bit = (^data) ^ odd_sel;
    endfunction

    // A divisor of zero behaves as the shortest bit
    function automatic logic [15:0] eff_divisor(input logic [15:0] div);
        eff_divisor = (div < DIVISOR_MIN) ? DIVISOR_MIN : div;
    endfunction

endpackage

// ===== logic/uart_flow_ctrl_multidrop.sv
module uart_flow_ctrl_multidrop (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] baud_divisor_high,
    input wire logic [7:0] baud_divisor_low,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic parity_enable,
    input wire logic parity_odd_select,
    input wire logic two_stop_bits,
    input wire logic flow_gate_enable,
    input wire logic addr_mode_enable,
    input wire logic [1:0] addr_match_scheme,
    input wire logic rx_int_errors_only,
    input wire logic tx_addr_flag,
    input wire logic [7:0] node_address,
    input wire logic [7:0] tx_data,
    input wire logic tx_data_write,
    input wire logic rx_data_read,
    input wire logic clear_to_send_n,
    input wire logic rx_serial,
    output logic tx_serial,
    output logic tx_holding_empty,
    output logic tx_irq,
    output logic [7:0] rx_data,
    output logic rx_data_valid,
    output logic rx_ninth_bit,
    output logic rx_new_frame,
    output logic rx_framing_error,
    output logic rx_parity_error,
    output logic rx_break_detect,
    output logic rx_overrun,
    output logic rx_irq
);

    // Shared bit period, in system clocks
    logic [15:0] baud_div;
    // Ninth bit present in the character
    logic ninth_used;
    // Parity active only outside multidrop mode
    logic parity_active;

    // Pin synchronisers, three stages each
    logic cts_s1_r, cts_s2_r, cts_s3_r;
    logic rxd_s1_r, rxd_s2_r, rxd_s3_r;
    // Filtered pin levels
    logic cts_n_level_r;
    logic rx_line_r;

    // Transmit side
    uart_pkg::tx_state_type tx_state_r;
    logic [15:0] tx_cnt_r;
    logic [2:0] tx_bits_r;
    logic tx_stops_r;
    logic [7:0] tx_shift_r;
    logic tx_ninth_r;
    logic [7:0] tx_hold_r;
    logic tx_serial_r;
    logic tx_holding_empty_r;
    logic tx_irq_r;
    logic tx_bit_done;
    logic tx_load;
    logic tx_flow_ok;

    // Receive side
    uart_pkg::rx_state_type rx_state_r;
    logic [15:0] rx_cnt_r;
    logic [2:0] rx_bits_r;
    logic [7:0] rx_shift_r;
    logic rx_ninth_in_r;
    logic rx_stop_level_r;
    logic rx_frame_done_r;
    logic rx_bit_done;
    logic rx_half_done;

    // Receive holding and status
    logic [7:0] rx_data_r;
    logic rx_data_valid_r;
    logic rx_ninth_bit_r;
    logic rx_new_frame_r;
    logic rx_framing_error_r;
    logic rx_parity_error_r;
    logic rx_break_detect_r;
    logic rx_overrun_r;
    logic rx_irq_r;
    logic rx_elig_r;
    // Current frame is addressed to this node
    logic frame_match_r;
    // Next data byte opens a new frame
    logic new_frame_pending_r;

    // Frame classification
    logic rx_is_addr;
    logic rx_addr_match;
    logic rx_accept;
    logic rx_irq_elig;
    logic rx_frame_err;
    logic rx_par_err;
    logic rx_break;

    // Divisor and format decode
    always_comb begin
        baud_div = uart_pkg::eff_divisor({baud_divisor_high, baud_divisor_low});
        parity_active = parity_enable & ~addr_mode_enable;
        ninth_used = addr_mode_enable | parity_enable;
    end

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cts_s1_r <= uart_pkg::LINE_IDLE;
            cts_s2_r <= uart_pkg::LINE_IDLE;
            cts_s3_r <= uart_pkg::LINE_IDLE;
            rxd_s1_r <= uart_pkg::LINE_IDLE;
            rxd_s2_r <= uart_pkg::LINE_IDLE;
            rxd_s3_r <= uart_pkg::LINE_IDLE;
        end else begin
            cts_s1_r <= clear_to_send_n;
            cts_s2_r <= cts_s1_r;
            cts_s3_r <= cts_s2_r;
            rxd_s1_r <= rx_serial;
            rxd_s2_r <= rxd_s1_r;
            rxd_s3_r <= rxd_s2_r;
        end
    end

    // A level change counts once the later two stages agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cts_n_level_r <= uart_pkg::LINE_IDLE;
            rx_line_r <= uart_pkg::LINE_IDLE;
        end else begin
            if (cts_s2_r == cts_s3_r) begin
                cts_n_level_r <= cts_s3_r;
            end
            if (rxd_s2_r == rxd_s3_r) begin
                rx_line_r <= rxd_s3_r;
            end
        end
    end

    // Transmit start decision, taken in the idle cycle before the start bit
    always_comb begin
        tx_flow_ok = ~flow_gate_enable | ~cts_n_level_r;
        tx_load = (tx_state_r == uart_pkg::TX_IDLE) & ~tx_holding_empty_r
            & tx_enable & tx_flow_ok;
        tx_bit_done = tx_cnt_r >= (baud_div - uart_pkg::COUNT_STEP);
    end

    // Holding register; a write while full is dropped to protect the byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_hold_r <= uart_pkg::BYTE_ZERO;
            tx_holding_empty_r <= 1'b1;
        end else begin
            if (tx_load) begin
                tx_holding_empty_r <= 1'b1;
            end else if (tx_data_write && tx_holding_empty_r) begin
                tx_hold_r <= tx_data;
                tx_holding_empty_r <= 1'b0;
            end
        end
    end

    // Transmit interrupt follows the empty flag, with no enable edge needed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_irq_r <= 1'b0;
        end else begin
            tx_irq_r <= tx_holding_empty_r;
        end
    end

    // Transmit shifter; once started a character always runs to its stop bits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_state_r <= uart_pkg::TX_IDLE;
            tx_cnt_r <= uart_pkg::COUNT_ZERO;
            tx_bits_r <= uart_pkg::FIRST_DATA_BIT;
            tx_stops_r <= uart_pkg::STOP_ONE;
            tx_shift_r <= uart_pkg::BYTE_ZERO;
            tx_ninth_r <= 1'b0;
            tx_serial_r <= uart_pkg::LINE_IDLE;
        end else begin
            unique case (tx_state_r)
                uart_pkg::TX_IDLE: begin
                    tx_cnt_r <= uart_pkg::COUNT_ZERO;
                    if (tx_load) begin
                        tx_shift_r <= tx_hold_r;
                        // Multidrop bit takes the parity position
                        tx_ninth_r <= addr_mode_enable ? tx_addr_flag
                            : uart_pkg::parity_bit(tx_hold_r, parity_odd_select);
                        tx_serial_r <= uart_pkg::LINE_START;
                        tx_state_r <= uart_pkg::TX_START;
                    end else begin
                        tx_serial_r <= uart_pkg::LINE_IDLE;
                    end
                end
                uart_pkg::TX_START: begin
                    if (tx_bit_done) begin
                        tx_cnt_r <= uart_pkg::COUNT_ZERO;
                        tx_bits_r <= uart_pkg::FIRST_DATA_BIT;
                        tx_serial_r <= tx_shift_r[0];
                        tx_state_r <= uart_pkg::TX_DATA;
                    end else begin
                        tx_cnt_r <= tx_cnt_r + uart_pkg::COUNT_STEP;
                    end
                end
                uart_pkg::TX_DATA: begin
                    if (tx_bit_done) begin
                        tx_cnt_r <= uart_pkg::COUNT_ZERO;
                        if (tx_bits_r == uart_pkg::LAST_DATA_BIT) begin
                            if (ninth_used) begin
                                tx_serial_r <= tx_ninth_r;
                                tx_state_r <= uart_pkg::TX_NINTH;
                            end else begin
                                tx_serial_r <= uart_pkg::LINE_IDLE;
                                tx_stops_r <= uart_pkg::STOP_ONE;
                                tx_state_r <= uart_pkg::TX_STOP;
                            end
                        end else begin
                            tx_bits_r <= tx_bits_r + 3'h1;
                            tx_shift_r <= tx_shift_r >> 1;
                            tx_serial_r <= tx_shift_r[1];
                        end
                    end else begin
                        tx_cnt_r <= tx_cnt_r + uart_pkg::COUNT_STEP;
                    end
                end
                uart_pkg::TX_NINTH: begin
                    if (tx_bit_done) begin
                        tx_cnt_r <= uart_pkg::COUNT_ZERO;
                        tx_serial_r <= uart_pkg::LINE_IDLE;
                        tx_stops_r <= uart_pkg::STOP_ONE;
                        tx_state_r <= uart_pkg::TX_STOP;
                    end else begin
                        tx_cnt_r <= tx_cnt_r + uart_pkg::COUNT_STEP;
                    end
                end
                uart_pkg::TX_STOP: begin
                    // Flow gate is not looked at here, so a pause waits for the end
                    if (tx_bit_done) begin
                        tx_cnt_r <= uart_pkg::COUNT_ZERO;
                        if (tx_stops_r == uart_pkg::STOP_TWO || !two_stop_bits) begin
                            tx_state_r <= uart_pkg::TX_IDLE;
                        end else begin
                            tx_stops_r <= uart_pkg::STOP_TWO;
                        end
                    end else begin
                        tx_cnt_r <= tx_cnt_r + uart_pkg::COUNT_STEP;
                    end
                end
            endcase
        end
    end

    // Receive bit timing; sampling sits mid-bit after the half-period wait
    always_comb begin
        rx_bit_done = rx_cnt_r >= (baud_div - uart_pkg::COUNT_STEP);
        rx_half_done = rx_cnt_r >= (baud_div >> 1);
    end

    // Receive shifter; only the first stop bit is checked
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_state_r <= uart_pkg::RX_IDLE;
            rx_cnt_r <= uart_pkg::COUNT_ZERO;
            rx_bits_r <= uart_pkg::FIRST_DATA_BIT;
            rx_shift_r <= uart_pkg::BYTE_ZERO;
            rx_ninth_in_r <= 1'b0;
            rx_stop_level_r <= uart_pkg::LINE_IDLE;
            rx_frame_done_r <= 1'b0;
        end else begin
            rx_frame_done_r <= 1'b0;
            if (!rx_enable) begin
                // Disabling drops a partial character
                rx_state_r <= uart_pkg::RX_IDLE;
                rx_cnt_r <= uart_pkg::COUNT_ZERO;
            end else begin
                unique case (rx_state_r)
                    uart_pkg::RX_IDLE: begin
                        rx_cnt_r <= uart_pkg::COUNT_ZERO;
                        if (rx_line_r == uart_pkg::LINE_START) begin
                            rx_state_r <= uart_pkg::RX_START;
                        end
                    end
                    uart_pkg::RX_START: begin
                        if (rx_half_done) begin
                            rx_cnt_r <= uart_pkg::COUNT_ZERO;
                            rx_bits_r <= uart_pkg::FIRST_DATA_BIT;
                            // A glitch shorter than half a bit is not a start
                            rx_state_r <= (rx_line_r == uart_pkg::LINE_START)
                                ? uart_pkg::RX_DATA : uart_pkg::RX_IDLE;
                        end else begin
                            rx_cnt_r <= rx_cnt_r + uart_pkg::COUNT_STEP;
                        end
                    end
                    uart_pkg::RX_DATA: begin
                        if (rx_bit_done) begin
                            rx_cnt_r <= uart_pkg::COUNT_ZERO;
                            rx_shift_r <= {rx_line_r, rx_shift_r[7:1]};
                            if (rx_bits_r == uart_pkg::LAST_DATA_BIT) begin
                                rx_state_r <= ninth_used ? uart_pkg::RX_NINTH
                                    : uart_pkg::RX_STOP;
                            end else begin
                                rx_bits_r <= rx_bits_r + 3'h1;
                            end
                        end else begin
                            rx_cnt_r <= rx_cnt_r + uart_pkg::COUNT_STEP;
                        end
                    end
                    uart_pkg::RX_NINTH: begin
                        if (rx_bit_done) begin
                            rx_cnt_r <= uart_pkg::COUNT_ZERO;
                            rx_ninth_in_r <= rx_line_r;
                            rx_state_r <= uart_pkg::RX_STOP;
                        end else begin
                            rx_cnt_r <= rx_cnt_r + uart_pkg::COUNT_STEP;
                        end
                    end
                    uart_pkg::RX_STOP: begin
                        if (rx_bit_done) begin
                            rx_cnt_r <= uart_pkg::COUNT_ZERO;
                            rx_stop_level_r <= rx_line_r;
                            rx_frame_done_r <= 1'b1;
                            rx_state_r <= uart_pkg::RX_IDLE;
                        end else begin
                            rx_cnt_r <= rx_cnt_r + uart_pkg::COUNT_STEP;
                        end
                    end
                endcase
            end
        end
    end

    // Classify the finished character for the selected scheme
    always_comb begin
        rx_is_addr = addr_mode_enable & rx_ninth_in_r;
        rx_addr_match = rx_shift_r == node_address;
        rx_frame_err = rx_stop_level_r != uart_pkg::LINE_IDLE;
        rx_par_err = parity_active
            & (rx_ninth_in_r != uart_pkg::parity_bit(rx_shift_r, parity_odd_select));
        rx_break = rx_frame_err & (rx_shift_r == uart_pkg::BYTE_ZERO) & ~rx_ninth_in_r;
        rx_accept = 1'b1;
        rx_irq_elig = 1'b1;
        if (addr_mode_enable) begin
            unique case (addr_match_scheme)
                uart_pkg::SCHEME_ALL_BYTES: begin
                    rx_accept = 1'b1;
                    rx_irq_elig = 1'b1;
                end
                uart_pkg::SCHEME_ADDR_ONLY: begin
                    rx_accept = 1'b1;
                    rx_irq_elig = rx_is_addr;
                end
                uart_pkg::SCHEME_MATCH_ADDR_DATA: begin
                    rx_accept = rx_is_addr ? rx_addr_match : frame_match_r;
                    rx_irq_elig = rx_accept;
                end
                uart_pkg::SCHEME_MATCH_DATA: begin
                    rx_accept = ~rx_is_addr & frame_match_r;
                    rx_irq_elig = rx_accept;
                end
            endcase
        end
    end

    // Receive register and status; a new byte wins over a same-cycle read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_data_r <= uart_pkg::BYTE_ZERO;
            rx_data_valid_r <= 1'b0;
            rx_ninth_bit_r <= 1'b0;
            rx_new_frame_r <= 1'b0;
            rx_framing_error_r <= 1'b0;
            rx_parity_error_r <= 1'b0;
            rx_break_detect_r <= 1'b0;
            rx_overrun_r <= 1'b0;
            rx_elig_r <= 1'b0;
            frame_match_r <= 1'b0;
            new_frame_pending_r <= 1'b0;
        end else begin
            if (rx_data_read) begin
                rx_data_valid_r <= 1'b0;
                rx_framing_error_r <= 1'b0;
                rx_parity_error_r <= 1'b0;
                rx_break_detect_r <= 1'b0;
                rx_overrun_r <= 1'b0;
                rx_elig_r <= 1'b0;
                rx_new_frame_r <= 1'b0;
            end
            if (rx_frame_done_r) begin
                if (rx_is_addr && addr_match_scheme[1]) begin
                    frame_match_r <= rx_addr_match;
                    new_frame_pending_r <= rx_addr_match;
                end
                if (rx_accept) begin
                    if (rx_data_valid_r && !rx_data_read) begin
                        // Unread byte is kept; the newcomer is lost
                        rx_overrun_r <= 1'b1;
                    end else begin
                        rx_data_r <= rx_shift_r;
                        rx_data_valid_r <= 1'b1;
                        rx_ninth_bit_r <= rx_is_addr;
                        rx_framing_error_r <= rx_frame_err;
                        rx_parity_error_r <= rx_par_err;
                        rx_break_detect_r <= rx_break;
                        rx_elig_r <= rx_irq_elig;
                        rx_new_frame_r <= ~rx_is_addr & new_frame_pending_r
                            & addr_match_scheme[1];
                        if (!rx_is_addr) begin
                            new_frame_pending_r <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // Receive interrupt: data only when allowed, errors always
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_irq_r <= 1'b0;
        end else begin
            rx_irq_r <= (rx_data_valid_r & rx_elig_r & ~rx_int_errors_only)
                | rx_framing_error_r | rx_parity_error_r | rx_break_detect_r | rx_overrun_r;
        end
    end

    // Outputs straight from flip-flops
    assign tx_serial = tx_serial_r;
    assign tx_holding_empty = tx_holding_empty_r;
    assign tx_irq = tx_irq_r;
    assign rx_data = rx_data_r;
    assign rx_data_valid = rx_data_valid_r;
    assign rx_ninth_bit = rx_ninth_bit_r;
    assign rx_new_frame = rx_new_frame_r;
    assign rx_framing_error = rx_framing_error_r;
    assign rx_parity_error = rx_parity_error_r;
    assign rx_break_detect = rx_break_detect_r;
    assign rx_overrun = rx_overrun_r;
    assign rx_irq = rx_irq_r;

endmodule

// ===== verif/uart_flow_ctrl_multidrop_sva.sv
module uart_flow_ctrl_multidrop_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tx_serial,
    input wire logic tx_holding_empty,
    input wire logic tx_irq,
    input wire logic tx_data_write,
    input wire logic rx_data_read,
    input wire logic rx_data_valid,
    input wire logic rx_irq,
    input wire logic rx_int_errors_only,
    input wire logic addr_mode_enable,
    input wire logic rx_framing_error,
    input wire logic rx_parity_error,
    input wire logic rx_overrun,
    input wire logic rx_break_detect
);
    timeunit 1ns;
    timeprecision 1ns;
    // Any error flag
    wire logic any_err = rx_framing_error | rx_parity_error | rx_overrun | rx_break_detect;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_idle_after_reset: assert property ($past(rst) |-> tx_serial && tx_holding_empty)
        else $error("line or holding flag wrong after reset");
    a_write_clears_empty: assert property (tx_data_write && tx_holding_empty |=> !tx_holding_empty)
        else $error("write did not clear holding empty");
    a_empty_holds: assert property (tx_holding_empty && !tx_data_write |=> tx_holding_empty)
        else $error("holding empty dropped without a write");
    a_irq_tracks_empty: assert property (!$past(rst) |-> tx_irq == $past(tx_holding_empty))
        else $error("tx interrupt does not follow holding empty");
    a_valid_stands: assert property (rx_data_valid && !rx_data_read |=> rx_data_valid)
        else $error("rx data valid lost without a read");
    a_read_no_overrun: assert property (rx_data_read |=> !rx_overrun)
        else $error("overrun flag left after a read");
    a_data_irq: assert property ($rose(rx_data_valid) && !addr_mode_enable
        && !rx_int_errors_only |=> rx_irq)
        else $error("no rx interrupt for new data");
    a_err_only_quiet: assert property ((rx_int_errors_only && !any_err) [*2] |-> !rx_irq)
        else $error("rx interrupt without error in errors-only mode");
    a_break_framed: assert property (rx_break_detect |-> rx_framing_error)
        else $error("break shown without framing error");
    c_tx_start: cover property ($fell(tx_serial));
    c_rx_data: cover property ($rose(rx_data_valid));
    c_rx_break: cover property ($rose(rx_break_detect));
endmodule

// ===== verif/remote_node.sv
module remote_node (
    input wire logic sys_clk,
    input wire logic [15:0] bit_len,
    input wire logic nine,
    input wire logic pause,
    input wire logic tx_serial,
    output logic rx_serial,
    output logic clear_to_send_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] got[$]; // Frames heard: stop, ninth, data
    logic [9:0] f; // Frame being assembled
    initial rx_serial = 1'b1;
    // Pause is timed by the bench, once to land just after a start bit has begun
    assign clear_to_send_n = pause;
    // Mid-bit sampling, never on a bit boundary, so no race with the shifter
    always begin
        @(negedge tx_serial);
        repeat (bit_len / 2) @(posedge sys_clk);
        f = 10'h000;
        for (int i = 0; i < 10; i++) begin
            if (i == 8 && !nine) continue;
            repeat (bit_len) @(posedge sys_clk);
            f[i] = tx_serial;
        end
        got.push_back(f);
    end
    // Drive one frame LSB first, then release to the idle high level
    task automatic send(input logic [10:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            rx_serial <= b[i];
            repeat (bit_len) @(posedge sys_clk);
        end
        rx_serial <= 1'b1;
    endtask
endmodule

// ===== verif/uart_flow_ctrl_multidrop_test.sv
module uart_flow_ctrl_multidrop_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0, rst = 1'h1, tx_enable = 1'h1, rx_enable = 1'h1, parity_enable = 1'h0;
    logic parity_odd_select = 1'h0, two_stop_bits = 1'h0, flow_gate_enable = 1'h0, pause = 1'h0;
    logic addr_mode_enable = 1'h0, rx_int_errors_only = 1'h0, tx_addr_flag = 1'h0;
    logic tx_data_write = 1'h0, rx_data_read = 1'h0, tx_serial, tx_holding_empty, tx_irq;
    logic rx_serial, clear_to_send_n, rx_data_valid, rx_ninth_bit, rx_new_frame, rx_irq;
    logic rx_framing_error, rx_parity_error, rx_break_detect, rx_overrun;
    logic [7:0] baud_divisor_high = 8'h00, baud_divisor_low = 8'h04, tx_data = 8'h00, d, rx_data;
    logic [7:0] node_address = 8'h5A;
    logic [1:0] addr_match_scheme = 2'h0;
    logic [9:0] exp_q[$]; // Frames the remote node should hear
    logic [31:0] seed = 32'h0000F94A; // Fixed start keeps runs repeatable
    int mismatches = 0, n_compared = 0, cycles = 0;
    localparam logic [13:0] FULL = 14'h1FFF, NODATA = 14'h1F00, ALL = 14'h3FFF;
    uart_flow_ctrl_multidrop u_dut (.*);
    remote_node u_node (.sys_clk, .bit_len({baud_divisor_high, baud_divisor_low}),
        .nine(addr_mode_enable | parity_enable), .pause, .tx_serial, .rx_serial,
        .clear_to_send_n);
    always #10 sys_clk = ~sys_clk;
    // Hang guard, far above the expected run of under two thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Ninth bit: address flag in multidrop, else parity when enabled
    function automatic logic [9:0] txe(input logic [7:0] v);
        return {1'h1, addr_mode_enable ? tx_addr_flag : parity_enable & (^v ^ parity_odd_select), v};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic put(input logic [7:0] v);
        for (int i = 0; i < 400 && tx_holding_empty !== 1'h1; i++) tick(1);
        tx_data = v;
        tx_data_write = 1'h1;
        exp_q.push_back(txe(v));
        tick(1);
        tx_data_write = 1'h0;
        check(tx_holding_empty, 16'h0000);
    endtask
    task automatic drain();
        for (int i = 0; i < 2000 && u_node.got.size() < exp_q.size(); i++) tick(1);
        while (exp_q.size() > 0) check(u_node.got.pop_front(), exp_q.pop_front());
        tick(12);
    endtask
    // Send a frame inward, compare status under mask k, then read it away
    task automatic rxc(input logic [7:0] v, input logic n9, input logic s,
            input logic [13:0] e, input logic [13:0] k);
        logic nn = addr_mode_enable | parity_enable;
        u_node.send(nn ? {s, n9, v, 1'h0} : {1'h1, s, v, 1'h0}, nn ? 11 : 10);
        tick(10);
        check({rx_new_frame, rx_irq, rx_break_detect, rx_framing_error, rx_parity_error,
            rx_data_valid, rx_data} & k, e & k);
        if (k[0]) check({rx_overrun, rx_ninth_bit}, {1'h0, n9 & addr_mode_enable});
        rx_data_read = 1'h1;
        tick(1);
        rx_data_read = 1'h0;
        tick(1);
    endtask
    initial begin
        tick(20);
        rst = 1'h0;
        tick(1);
        check({tx_serial, tx_holding_empty, rx_data_valid}, 16'h0006);
        // Plain, even two-stop, odd, address data, address with parity enable set but unused in multidrop
        for (int m = 0; m < 5; m++) begin
            parity_enable = (m == 1 || m == 2 || m == 4);
            parity_odd_select = (m == 2);
            two_stop_bits = (m == 1);
            addr_mode_enable = (m > 2);
            tx_addr_flag = (m == 4);
            put(rnd());
            put(m[0] ? 8'hFF : 8'h00);
            drain();
        end
        tx_enable = 1'h0;
        put(rnd());
        tick(40);
        check(u_node.got.size(), 16'h0000);
        tx_enable = 1'h1;
        pause = 1'h1;
        drain();
        flow_gate_enable = 1'h1;
        put(rnd());
        tick(40);
        check(u_node.got.size(), 16'h0000);
        pause = 1'h0;
        for (int i = 0; i < 100 && tx_serial !== 1'h0; i++) tick(1);
        pause = 1'h1;
        drain();
        put(rnd());
        tick(40);
        flow_gate_enable = 1'h0;
        drain();
        pause = 1'h0;
        parity_enable = 1'h0;
        addr_mode_enable = 1'h0;
        d = rnd();
        rxc(d, 1'h0, 1'h1, {6'h11, d}, FULL);
        rx_enable = 1'h0;
        rxc(d, 1'h0, 1'h1, 14'h0000, NODATA);
        rx_enable = 1'h1;
        rx_int_errors_only = 1'h1;
        rxc(d, 1'h0, 1'h1, {6'h01, d}, FULL);
        rxc(8'h00, 1'h0, 1'h0, 14'h1C00, 14'h1E00);
        rx_int_errors_only = 1'h0;
        parity_enable = 1'h1;
        parity_odd_select = 1'h1;
        rxc(d, ^d, 1'h1, 14'h1200, 14'h1E00);
        rxc(d, ~^d, 1'h1, {6'h11, d}, FULL);
        parity_enable = 1'h0;
        addr_mode_enable = 1'h1;
        addr_match_scheme = 2'h2;
        rxc(8'h5A, 1'h1, 1'h1, {6'h11, 8'h5A}, FULL);
        rxc(d, 1'h0, 1'h1, {6'h31, d}, ALL);
        rxc(8'h33, 1'h1, 1'h1, 14'h0000, NODATA);
        rxc(d, 1'h0, 1'h1, 14'h0000, NODATA);
        addr_match_scheme = 2'h3;
        rxc(8'h5A, 1'h1, 1'h1, 14'h0000, NODATA);
        rxc(d, 1'h0, 1'h1, {6'h31, d}, ALL);
        addr_match_scheme = 2'h1;
        rxc(8'h33, 1'h1, 1'h1, {6'h11, 8'h33}, FULL);
        rxc(d, 1'h0, 1'h1, {6'h01, d}, FULL);
        addr_mode_enable = 1'h0;
        baud_divisor_low = 8'h06;
        put(rnd());
        drain();
        rxc(d, 1'h0, 1'h1, {6'h11, d}, FULL);
        stop_test();
    end
endmodule
bind uart_flow_ctrl_multidrop uart_flow_ctrl_multidrop_sva u_sva (.*);
